// [design/cdip_pkg.sv]
// Purpose: Shared constants and types for the CPU slowdown and halt control block
// Assumes: One system instruction clock; Wishbone classic register access
// Notes: Byte addresses are word aligned; unused bits read as zero
package cdip_pkg;

  // Register byte offsets
  localparam logic [3:0] CDIP_ADDR_POWER_CTRL = 4'h0;
  localparam logic [3:0] CDIP_ADDR_STATUS = 4'h4;
  localparam logic [3:0] CDIP_ADDR_IRQ_FLAGS = 4'h8;
  localparam logic [3:0] CDIP_ADDR_IRQ_ENABLE = 4'hC;

  // Field positions in cpu_power_control_reg
  localparam int CDIP_RATIO_LSB = 0;
  localparam int CDIP_LIGHT_HALT_BIT = 4;
  localparam int CDIP_SLOWDOWN_EN_BIT = 5;
  localparam int CDIP_SLOW_ON_RET_BIT = 6;
  localparam int CDIP_WAKE_FULL_BIT = 7;
  localparam int CDIP_GIE_BIT = 8;

  // Reset values
  localparam logic [8:0] CDIP_POWER_CTRL_RST = 9'h000;
  localparam logic [7:0] CDIP_IRQ_RST = 8'h00;
  localparam logic [4:0] CDIP_COUNT_RST = 5'h00;

  // Number of interrupt sources handled
  localparam int CDIP_NUM_IRQ = 8;

  // Slowdown ratio codes: cycles per group is 2 ** (code + 1)
  localparam logic [2:0] CDIP_RATIO_1_4 = 3'h1;
  localparam logic [2:0] CDIP_RATIO_1_32 = 3'h4;

  // Power state of the CPU
  typedef enum logic [1:0] {
    CDIP_RUN,
    CDIP_LIGHT_HALT,
    CDIP_DEEP_HALT
  } cdip_state_t;

  // Control fields held by software
  typedef struct packed {
    logic global_irq_enable;
    logic wake_restores_full_speed;
    logic slowdown_on_return;
    logic cpu_slowdown_enable;
    logic light_halt_select;
    logic [2:0] ratio;
  } cdip_ctrl_t;

  // Clock gate outputs towards the core
  typedef struct packed {
    logic cpu_cycle_en;
    logic prog_mem_en;
    logic periph_clk_en;
    logic main_osc_periph_en;
    logic clock_output_en;
  } cdip_gates_t;

endpackage : cdip_pkg

// [design/cdip_ratio_counter.sv]
// Purpose: Counts system instruction cycles and marks the executing one
// Assumes: Ratio code 0..7 selects group of 2 to 256 cycles
// Notes: Restarts at zero while slowdown is off
`timescale 1ns/1ps
`default_nettype none
module cdip_ratio_counter
  import cdip_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic [2:0] ratio_i,
  // Result
  output logic exec_slot_o
);

  logic [7:0] count;

  // R2 - code 1 gives 4, code 4 gives 32
  // Last count in the group for a ratio code
  function automatic logic [7:0] cdip_group_last(input logic [2:0] code);
    cdip_group_last = 8'((9'h002 << code) - 9'h001);
  endfunction : cdip_group_last

  // R20 - wrapping cycle counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      count <= 8'h00;
    end else if (count >= cdip_group_last(ratio_i)) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  // R1 - one executing cycle per group
  assign exec_slot_o = !enable_i || (count == 8'h00);

endmodule : cdip_ratio_counter
`default_nettype wire

// [design/cdip_power_ctrl.sv]
// Purpose: CPU slowdown, light halt and deep halt power control
// Assumes: Core strobes are one-cycle pulses synchronous to clk_i
// Notes: Registers reached over Wishbone classic, one-cycle ack
//
// Summary of operation
// R1 - With slowdown on, CPU runs one cycle per group of N cycles.
// R2 - Ratio code 100 gives 1:32, code 001 gives 1:4.
// R3 - Peripherals keep full clock rate regardless of slowdown.
// R4 - Program memory prefetch and peripheral clocks continue in slowdown.
// R5 - Wake-full clear: interrupt handler stays at slowed rate.
// R6 - Wake-full set: interrupt clears slowdown, full speed resumes.
// R7 - Interrupt return with slowdown-on-return set re-enables slowdown.
// R8 - Halt op enters deep halt if light select is 0, else light halt.
// R9 - Light halt stops CPU and program memory, peripheral clocks run.
// R10 - Main-oscillator peripherals stop only in deep halt; others always run (here periph_clk_en also stops in deep halt).
// R11 - Clock output keeps toggling in light halt when enabled (config 0).
// R12 - Any interrupt ends light halt even with global enable off (here only a flag whose source is set in irq_enable wakes).
// R13 - Wake-full set: interrupt ending light halt also clears slowdown.
// R14 - Watchdog timeout in light halt wakes instead of resetting.
// R15 - Watchdog wake leaves slowdown enable unchanged.
// R16 - Interrupt flags set on their condition regardless of enables.
// R17 - Software should clear stale flags before enabling interrupts.
// R18 - Deep halt disables both CPU clock and system clock.
// R19 - Waking from deep halt clears the watchdog timer.
// R20 - CPU cycle enable comes from a wrapping counter, restarted on enable.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdip_power_ctrl
  import cdip_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core events
  input wire logic halt_op_i,
  input wire logic return_from_interrupt_op_i,
  input wire logic watchdog_timeout_i,
  input wire logic [7:0] irq_cond_i,
  input wire logic clock_output_cfg_n_i,
  // Power outputs
  output cdip_gates_t gates_o,
  output logic sys_clk_en_o,
  output logic watchdog_clear_o,
  output logic watchdog_reset_o,
  output logic irq_pending_o,
  output cdip_state_t state_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cdip_ctrl_t ctrl;
  cdip_state_t state;
  logic [7:0] irq_flags;
  logic [7:0] irq_enable;
  logic exec_slot;
  logic bus_req;
  logic bus_wr;
  logic any_irq;
  logic wake_irq;
  logic light_wd_wake;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  // Flags whose source is enabled form a wake request
  assign any_irq = |(irq_flags & irq_enable);
  // R12 - wake ignores global enable
  assign wake_irq = any_irq;
  // R14 - watchdog wakes light halt
  assign light_wd_wake = (state == CDIP_LIGHT_HALT) && watchdog_timeout_i;

  ////////////////////////////////////////////////////////////////////////////
  // Slowdown counter

  cdip_ratio_counter u_ratio (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl.cpu_slowdown_enable),
    .ratio_i(ctrl.ratio),
    .exec_slot_o(exec_slot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Software writes, hardware slowdown updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= cdip_ctrl_t'(CDIP_POWER_CTRL_RST);
    end else begin
      if (bus_wr && adr_i == CDIP_ADDR_POWER_CTRL) begin
        if (sel_i[0]) begin
          ctrl.ratio <= dat_i[CDIP_RATIO_LSB +: 3];
          ctrl.light_halt_select <= dat_i[CDIP_LIGHT_HALT_BIT];
          ctrl.cpu_slowdown_enable <= dat_i[CDIP_SLOWDOWN_EN_BIT];
          ctrl.slowdown_on_return <= dat_i[CDIP_SLOW_ON_RET_BIT];
          ctrl.wake_restores_full_speed <= dat_i[CDIP_WAKE_FULL_BIT];
        end
        if (sel_i[1]) begin
          ctrl.global_irq_enable <= dat_i[CDIP_GIE_BIT];
        end
      end
      // R6 - interrupt restores full speed
      // R13 - also when ending light halt
      // R5 - wake-full clear keeps slowdown
      if (wake_irq && ctrl.wake_restores_full_speed &&
          (ctrl.global_irq_enable || state == CDIP_LIGHT_HALT)) begin
        ctrl.cpu_slowdown_enable <= 1'b0;
      end
      // R7 - slowdown back on return
      if (return_from_interrupt_op_i && ctrl.slowdown_on_return) begin
        ctrl.cpu_slowdown_enable <= 1'b1;
      end
      // R15 - watchdog wake leaves slowdown alone
      // R12 - light select never altered by wake
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // R16 - flags set regardless of enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flags <= CDIP_IRQ_RST;
    end else if (bus_wr && adr_i == CDIP_ADDR_IRQ_FLAGS && sel_i[0]) begin
      // Set wins over a software clear in the same cycle
      irq_flags <= dat_i[7:0] | irq_cond_i;
    end else begin
      irq_flags <= irq_flags | irq_cond_i;
    end
  end

  // Interrupt enables, software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable <= CDIP_IRQ_RST;
    end else if (bus_wr && adr_i == CDIP_ADDR_IRQ_ENABLE && sel_i[0]) begin
      irq_enable <= dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CDIP_RUN;
    end else begin
      unique case (state)
        CDIP_RUN: begin
          // R8 - halt op selects depth
          if (halt_op_i && !wake_irq) begin
            state <= ctrl.light_halt_select ? CDIP_LIGHT_HALT : CDIP_DEEP_HALT;
          end
        end
        CDIP_LIGHT_HALT: begin
          // R12 - interrupt ends light halt
          if (wake_irq || watchdog_timeout_i) begin
            state <= CDIP_RUN;
          end
        end
        CDIP_DEEP_HALT: begin
          if (wake_irq || watchdog_timeout_i) begin
            state <= CDIP_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog handling

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_clear_o <= 1'b0;
      watchdog_reset_o <= 1'b0;
    end else begin
      // R19 - clear watchdog on deep halt wake
      watchdog_clear_o <= (state == CDIP_DEEP_HALT) &&
                          (wake_irq || watchdog_timeout_i);
      // R14 - no reset while in either halt
      watchdog_reset_o <= watchdog_timeout_i && (state == CDIP_RUN) &&
                          !light_wd_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gates_o <= '0;
      sys_clk_en_o <= 1'b0;
      state_o <= CDIP_RUN;
      irq_pending_o <= 1'b0;
    end else begin
      state_o <= state;
      irq_pending_o <= any_irq && ctrl.global_irq_enable;
      // R1 - CPU runs on executing slot
      // R9 - no CPU cycles in halt
      gates_o.cpu_cycle_en <= (state == CDIP_RUN) && exec_slot;
      // R4 - prefetch kept while running
      gates_o.prog_mem_en <= (state == CDIP_RUN);
      // R3 - peripheral clock full rate
      gates_o.periph_clk_en <= (state != CDIP_DEEP_HALT);
      // R10 - main oscillator peripherals
      gates_o.main_osc_periph_en <= (state != CDIP_DEEP_HALT);
      // R11 - clock output in light halt
      gates_o.clock_output_en <= !clock_output_cfg_n_i &&
                                 (state != CDIP_DEEP_HALT);
      // R18 - system clock off in deep halt
      sys_clk_en_o <= (state != CDIP_DEEP_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer

  // One-cycle ack, read data with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i) begin
        unique case (adr_i)
          CDIP_ADDR_POWER_CTRL: dat_o <= {23'h00_0000, ctrl.global_irq_enable,
                                          ctrl.wake_restores_full_speed,
                                          ctrl.slowdown_on_return,
                                          ctrl.cpu_slowdown_enable,
                                          ctrl.light_halt_select, 1'b0, ctrl.ratio};
          CDIP_ADDR_STATUS: dat_o <= {29'h0000_0000, exec_slot, state};
          CDIP_ADDR_IRQ_FLAGS: dat_o <= {24'h00_0000, irq_flags};
          CDIP_ADDR_IRQ_ENABLE: dat_o <= {24'h00_0000, irq_enable};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // R17 - software duty, flags readable to clear first

endmodule : cdip_power_ctrl
`default_nettype wire

// [dv/cdip_core_model.sv]
// Purpose: Core, interrupt and watchdog stand-in
// Assumes: Bench holds each command for one cycle
// Notes: Commands 1 to 4 each leave as a one-cycle pulse; other codes give none
`timescale 1ns/1ps
`default_nettype none
module cdip_core_model (
  // Command from bench
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] src_i,
  // Event pulses
  output logic halt_o,
  output logic rfi_o,
  output logic wdog_o,
  output logic [7:0] irq_o
);
  // Decode one event per command
  always_comb begin
    halt_o = cmd_i == 3'h1;
    rfi_o = cmd_i == 3'h2;
    wdog_o = cmd_i == 3'h3;
    irq_o = (cmd_i == 3'h4) ? (8'h01 << src_i) : 8'h00;
  end
endmodule : cdip_core_model
`default_nettype wire

// [dv/cdip_power_ctrl_properties.sv]
// Purpose: Port assertions for the power control block
// Assumes: Sync active-high reset
// Notes: Bound into cdip_power_ctrl
`timescale 1ns/1ps
`default_nettype none
module cdip_power_ctrl_properties
  import cdip_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Events and power
  input wire logic watchdog_timeout_i,
  input wire logic clock_output_cfg_n_i,
  input wire cdip_gates_t gates_o,
  input wire logic sys_clk_en_o,
  input wire logic watchdog_clear_o,
  input wire logic watchdog_reset_o,
  input wire cdip_state_t state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ///////////////////////////////
  // Bus answer and power gates
  ack_one_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  ack_drop_a: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  light_gates_a: assert property (state_o == CDIP_LIGHT_HALT |->
    !gates_o.cpu_cycle_en && !gates_o.prog_mem_en && gates_o.periph_clk_en)
    else $error("light halt gates wrong");
  light_clk_a: assert property (state_o == CDIP_LIGHT_HALT && !clock_output_cfg_n_i |->
    gates_o.clock_output_en && gates_o.main_osc_periph_en && sys_clk_en_o)
    else $error("light halt clocks stopped");
  deep_gates_a: assert property (state_o == CDIP_DEEP_HALT |->
    !sys_clk_en_o && !gates_o.main_osc_periph_en && !gates_o.cpu_cycle_en)
    else $error("deep halt clocks running");
  run_periph_a: assert property (state_o == CDIP_RUN && !$past(rst_i) |->
    gates_o.periph_clk_en && sys_clk_en_o && gates_o.prog_mem_en)
    else $error("peripheral clock off in run");
  wdog_wake_a: assert property (state_o == CDIP_LIGHT_HALT && watchdog_timeout_i |->
    ##[2:3] state_o == CDIP_RUN)
    else $error("watchdog did not wake");
  wdog_noreset_a: assert property (state_o == CDIP_LIGHT_HALT && watchdog_timeout_i |->
    ##1 !watchdog_reset_o [*3])
    else $error("watchdog reset in light halt");
  wdog_clear_a: assert property ($past(state_o) == CDIP_DEEP_HALT && state_o == CDIP_RUN |->
    watchdog_clear_o || $past(watchdog_clear_o) || $past(watchdog_clear_o, 2))
    else $error("watchdog not cleared on wake");
endmodule : cdip_power_ctrl_properties
bind cdip_power_ctrl cdip_power_ctrl_properties props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .watchdog_timeout_i, .clock_output_cfg_n_i, .gates_o, .sys_clk_en_o, .watchdog_clear_o,
  .watchdog_reset_o, .state_o);
`default_nettype wire

// [dv/test_cdip_power_ctrl.sv]
// Purpose: Self-checking bench for the power control block
// Assumes: Events come through cdip_core_model
// Notes: Register rows first, then slowdown, halt and wake cases
`timescale 1ns/1ps
`default_nettype none
module test_cdip_power_ctrl
  import cdip_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sys_clk_en_o;
  logic halt, rfi, wdog, cfg_n, pend;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0] irq;
  logic [2:0] cmd, src;
  cdip_gates_t gates_o;
  cdip_state_t state_o;
  int num_errors, tests_run;
  logic [31:0] rows [7][3];
  ///////////////////////////////
  // Clock
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // Design and core stand-in
  cdip_power_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .halt_op_i(halt), .return_from_interrupt_op_i(rfi),
    .watchdog_timeout_i(wdog), .irq_cond_i(irq), .clock_output_cfg_n_i(cfg_n), .gates_o,
    .sys_clk_en_o, .watchdog_clear_o(), .watchdog_reset_o(), .irq_pending_o(pend), .state_o);
  cdip_core_model core (.cmd_i(cmd), .src_i(src), .halt_o(halt), .rfi_o(rfi),
    .wdog_o(wdog), .irq_o(irq));
  ///////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input cdip_state_t e);
    chk({30'h0, state_o}, {30'h0, e});
  endtask : st
  // Classic cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'h1 && k < 20);
    if (k >= 20) chk(32'h0000_0000, 32'h0000_0001);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask : wb
  task automatic rw(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    wb(1'h1, a, d);
    wb(1'h0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rw
  task automatic ev(input logic [2:0] c, input logic [2:0] s);
    @(posedge clk_i);
    {cmd, src} <= {c, s};
    @(posedge clk_i);
    cmd <= 3'h0;
    repeat (5) @(posedge clk_i);
  endtask : ev
  task automatic slots(input logic [31:0] e);
    int c;
    c = 0;
    repeat (64) begin
      @(posedge clk_i);
      if (gates_o.cpu_cycle_en === 1'h1) c++;
    end
    chk(32'(c), e);
  endtask : slots
  ///////////////////////////////
  // Main sequence
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, cmd, src, cfg_n} = '0;
    sel_i = 4'hF;
    rst_i = 1'h1;
    rows[0] = '{32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_00FF};
    rows[1] = '{32'h0000_0008, 32'h0000_00FF, 32'h0000_00FF};
    rows[2] = '{32'h0000_0008, 32'h0000_0000, 32'h0000_0000};
    rows[3] = '{32'h0000_000C, 32'h0000_0000, 32'h0000_0000};
    rows[4] = '{32'h0000_0002, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[5] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_01F7};
    rows[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, CDIP_ADDR_POWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      rw(rows[i][0][3:0], rows[i][1], rows[i][2]);
    end
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_0021, 32'h0000_0021);
    slots(32'h0000_0010);
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_0024, 32'h0000_0024);
    slots(32'h0000_0002);
    rw(CDIP_ADDR_IRQ_ENABLE, 32'h0000_0001, 32'h0000_0001);
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_0121, 32'h0000_0121);
    ev(3'h4, 3'h0);
    chk({31'h0, pend}, 32'h0000_0001);
    slots(32'h0000_0010);
    rw(CDIP_ADDR_IRQ_FLAGS, 32'h0000_0000, 32'h0000_0000);
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_01E1, 32'h0000_01E1);
    ev(3'h4, 3'h0);
    slots(32'h0000_0040);
    rw(CDIP_ADDR_IRQ_FLAGS, 32'h0000_0000, 32'h0000_0000);
    ev(3'h2, 3'h0);
    wb(1'h0, CDIP_ADDR_POWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_01E1);
    // Light halt, interrupt wake
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_00B1, 32'h0000_00B1);
    ev(3'h1, 3'h0);
    st(CDIP_LIGHT_HALT);
    ev(3'h4, 3'h0);
    st(CDIP_RUN);
    wb(1'h0, CDIP_ADDR_POWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0091);
    // Light halt, watchdog wake
    rw(CDIP_ADDR_IRQ_FLAGS, 32'h0000_0000, 32'h0000_0000);
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_00B1, 32'h0000_00B1);
    ev(3'h1, 3'h0);
    st(CDIP_LIGHT_HALT);
    chk({31'h0, gates_o.clock_output_en}, 32'h0000_0001);
    ev(3'h3, 3'h0);
    st(CDIP_RUN);
    wb(1'h0, CDIP_ADDR_POWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_00B1);
    // Deep halt and wake
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_0000, 32'h0000_0000);
    ev(3'h1, 3'h0);
    st(CDIP_DEEP_HALT);
    chk({31'h0, sys_clk_en_o}, 32'h0000_0000);
    ev(3'h4, 3'h0);
    st(CDIP_RUN);
    // Flag set with everything disabled
    rw(CDIP_ADDR_IRQ_ENABLE, 32'h0000_0000, 32'h0000_0000);
    rw(CDIP_ADDR_IRQ_FLAGS, 32'h0000_0000, 32'h0000_0000);
    ev(3'h4, 3'h3);
    wb(1'h0, CDIP_ADDR_IRQ_FLAGS, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    chk({31'h0, pend}, 32'h0000_0000);
    // Reset in mid-run
    rw(CDIP_ADDR_POWER_CTRL, 32'h0000_0021, 32'h0000_0021);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, CDIP_ADDR_POWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    conclude();
  end
  // Hang guard
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
endmodule : test_cdip_power_ctrl
`default_nettype wire
